// file: hdl/shrp_pkg.sv
// Package with constants and carrier types for the serial host register port
package shrp_pkg;
  // ==========================================================================
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 7;
  localparam int DATA_BITS = 8;
  localparam int ADDR_LSB = 8;
  localparam int RW_POS = 15;
  localparam int REG_COUNT = 128;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [3:0] CNT_DATA = 4'h8;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;
  // ==========================================================================
  // Register access carriers
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } shrp_wr_s;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } shrp_rd_s;
  typedef enum logic [2:0] {
    SHRP_IDLE = 3'b001,
    SHRP_HEAD = 3'b010,
    SHRP_DATA = 3'b100
  } shrp_state_e;
endpackage : shrp_pkg

// file: hdl/shrp_port.sv
// Serial host register port with register file, interrupt line and reset
`timescale 1ns/1ps
module shrp_port (
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_n,
  // Mode and hardware reset pin
  input wire logic control_mode_select,
  input wire logic hw_reset_n,
  // Interrupt sources and request
  input wire logic [7:0] irq_event,
  output logic irq_n,
  // Register contents and monitor select to the core
  output logic [shrp_pkg::REG_COUNT*8-1:0] reg_image,
  output logic receive_monitor_select
);
  import shrp_pkg::*;

  // ==========================================================================
  // Link domain: shift in on rising edge
  logic [3:0] cnt_q, cnt_d;
  logic [14:0] sh_q, sh_d;
  logic wr_tog_q, wr_tog_d;
  shrp_wr_s wr_q, wr_d;
  logic [6:0] raddr_q, raddr_d;
  logic rd_q, rd_d;
  logic host_mode;
  logic link_rst_n;
  logic link_clr;
  logic [7:0] rd_data;
  shrp_state_e phase_q, phase_d;
  logic mode_q, mode_d;

  assign host_mode = mode_q;
  assign link_rst_n = hw_reset_n;
  // Frame logic clears on deselect and on the hardware reset pin
  assign link_clr = chip_select_n || !hw_reset_n;

  always_comb
  begin
    cnt_d = cnt_q + 4'h1;
    sh_d = {sh_q[13:0], serial_data_in};
    wr_tog_d = wr_tog_q;
    wr_d = wr_q;
    raddr_d = raddr_q;
    rd_d = rd_q;
    if (cnt_q == 4'h7)
    begin
      raddr_d = sh_d[6:0];
      rd_d = sh_d[7];
    end
    if (cnt_q == CNT_LAST && !sh_q[14] && phase_q == SHRP_DATA)
    begin
      wr_d.addr = sh_q[13:7];
      wr_d.data = {sh_q[6:0], serial_data_in};
      wr_tog_d = ~wr_tog_q;
    end
  end

  always_ff @(posedge serial_clk or posedge link_clr)
  begin
    if (link_clr)
    begin
      cnt_q <= 4'h0;
      sh_q <= 15'h0000;
      rd_q <= 1'b0;
      raddr_q <= 7'h00;
    end
    else
    begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rd_q <= rd_d;
      raddr_q <= raddr_d;
    end
  end

  // ==========================================================================
  // Link domain: frame phase
  always_comb
  begin
    phase_d = phase_q;
    unique case (phase_q)
      SHRP_IDLE:
      begin
        phase_d = SHRP_HEAD;
      end
      SHRP_HEAD:
      begin
        if (cnt_q == 4'h7)
        begin
          phase_d = SHRP_DATA;
        end
      end
      SHRP_DATA:
      begin
        if (cnt_q == CNT_LAST)
        begin
          phase_d = SHRP_IDLE;
        end
      end
      default:
      begin
        phase_d = SHRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge serial_clk or posedge link_clr)
  begin
    if (link_clr)
    begin
      phase_q <= SHRP_IDLE;
    end
    else
    begin
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge serial_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      wr_tog_q <= 1'b0;
      wr_q <= '0;
    end
    else if (!chip_select_n)
    begin
      wr_tog_q <= wr_tog_d;
      wr_q <= wr_d;
    end
  end

  // ==========================================================================
  // Link domain: shift out on falling edge
  logic [7:0] out_q, out_d;
  logic oe_q, oe_d;

  always_comb
  begin
    out_d = {out_q[6:0], 1'b0};
    oe_d = oe_q;
    if (cnt_q == CNT_DATA && rd_q)
    begin
      out_d = rd_data;
      oe_d = 1'b1;
    end
    else if (cnt_q == 4'h0)
    begin
      oe_d = 1'b0;
    end
  end

  always_ff @(negedge serial_clk or posedge link_clr)
  begin
    if (link_clr)
    begin
      out_q <= 8'h00;
      oe_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign serial_data_out_o = out_q[7];
  assign serial_data_out_oe_n = ~(oe_q && host_mode && !chip_select_n);

  // ==========================================================================
  // System domain: crossings and register file
  logic [2:0] tog_s_q;
  logic tog_old_q;
  logic [2:0] mon_s_q;
  logic mon_q, mon_d;
  logic [2:0] hrst_s_q;
  logic [7:0] regs_q [REG_COUNT];
  logic [7:0] regs_d [REG_COUNT];
  logic sys_clr;
  logic [2:0] mode_s_q;
  logic wr_seen;

  // Toggle change once the last two stages agree
  function automatic logic tog_seen(input logic [2:0] s, input logic old);
    return (s[2] == s[1]) && (s[2] != old);
  endfunction : tog_seen

  assign wr_seen = tog_seen(tog_s_q, tog_old_q);

  // Mode select pin, filtered
  always_comb
  begin
    mode_d = mode_q;
    if (mode_s_q[2] == mode_s_q[1])
    begin
      mode_d = mode_s_q[2];
    end
  end

  always_ff @(posedge clk)
  begin
    mode_s_q <= {mode_s_q[1:0], control_mode_select};
    if (!rst_n)
    begin
      mode_q <= 1'b1;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // Hardware reset pin, filtered
  assign sys_clr = !rst_n || (!hrst_s_q[2] && !hrst_s_q[1]);

  // Read path is quasi-static: address is held before data phase
  assign rd_data = regs_q[raddr_q];

  always_comb
  begin
    regs_d = regs_q;
    if (wr_seen)
    begin
      regs_d[wr_q.addr] = wr_q.data;
    end
    mon_d = mon_q;
    if (mon_s_q[2] == mon_s_q[1])
    begin
      mon_d = mon_s_q[2];
    end
  end

  always_ff @(posedge clk)
  begin
    tog_s_q <= {tog_s_q[1:0], wr_tog_q};
    hrst_s_q <= {hrst_s_q[1:0], hw_reset_n};
    mon_s_q <= {mon_s_q[1:0], serial_data_out_i};
    if (!rst_n)
    begin
      tog_old_q <= 1'b0;
      mon_q <= 1'b0;
    end
    else
    begin
      tog_old_q <= tog_s_q[2];
      mon_q <= mon_d;
    end
    for (int i = 0; i < REG_COUNT; i++)
    begin
      regs_q[i] <= sys_clr ? REG_RESET : regs_d[i];
    end
  end

  always_comb
  begin
    for (int i = 0; i < REG_COUNT; i++)
    begin
      reg_image[i*8 +: 8] = regs_q[i];
    end
  end

  assign receive_monitor_select = host_mode ? 1'b0 : mon_q;

  // ==========================================================================
  // Interrupt: register 0 enables, pending held outside the file, write one to register 1 to clear
  logic [7:0] pend_q, pend_d;
  logic clr_hit;

  assign clr_hit = wr_seen && (wr_q.addr == 7'h01);

  always_comb
  begin
    pend_d = pend_q;
    if (clr_hit)
    begin
      pend_d = pend_q & ~wr_q.data;
    end
    pend_d = pend_d | (irq_event & regs_q[0]);
  end

  always_ff @(posedge clk)
  begin
    if (sys_clr)
    begin
      pend_q <= 8'h00;
    end
    else
    begin
      pend_q <= pend_d;
    end
  end

  assign irq_n = ~(host_mode && |pend_q);
endmodule : shrp_port

// file: verification/shrp_host_model.sv
// Host side serial master model
`timescale 1ns/1ps
// ====
// Master
module shrp_host_model (
  // Serial link
  output logic serial_clk = 0,
  output logic chip_select_n = 1,
  output logic serial_data_in = 0,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_n
);
  task automatic frame(input logic [15:0] f, output logic [7:0] q);
    chip_select_n = 0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_data_in = f[i];
      #7.5 serial_clk = 1;
      if (i < 8) q[i] = serial_data_out_oe_n ? 1'bx : serial_data_out_o;
      #7.5 serial_clk = 0;
    end
    #7.5 chip_select_n = 1;
    serial_data_in = ~serial_data_in;
  endtask : frame
endmodule : shrp_host_model

// file: verification/shrp_port_bench.sv
// Bench for the serial host register port
`timescale 1ns/1ps
// ====
// Bench
module shrp_port_bench;
  import shrp_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic control_mode_select = 1;
  logic hw_reset_n = 0;
  logic mon = 0;
  logic [7:0] irq_event = 8'h00;
  logic [7:0] q;
  logic serial_clk, chip_select_n, serial_data_in, serial_data_out_o;
  logic serial_data_out_oe_n, irq_n, receive_monitor_select;
  logic [REG_COUNT*8-1:0] reg_image;
  int error_cnt = 0;
  int compares = 0;
  shrp_host_model i_shrp_host_model (.serial_clk, .chip_select_n, .serial_data_in,
    .serial_data_out_o, .serial_data_out_oe_n);
  shrp_port i_shrp_port (.clk, .rst_n, .serial_clk, .chip_select_n, .serial_data_in,
    .serial_data_out_i(serial_data_out_oe_n ? mon : serial_data_out_o), .serial_data_out_o,
    .serial_data_out_oe_n, .control_mode_select, .hw_reset_n, .irq_event, .irq_n,
    .reg_image, .receive_monitor_select);
  initial forever #2 clk = ~clk;
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic xfer(input logic [15:0] f);
    i_shrp_host_model.frame(f, q);
    repeat (8) @(negedge clk);
  endtask : xfer
  task automatic t_regs;
    xfer(16'h05A5);
    xfer(16'h7F3C);
    cmp("img5", 8'hA5, reg_image[47:40]);
    xfer(16'h8500);
    cmp("rd5", 8'hA5, q);
    xfer(16'hFF00);
    cmp("rd7f", 8'h3C, q);
    cmp("oe", 8'h01, {7'h0, serial_data_out_oe_n});
    $display("t_regs done");
  endtask : t_regs
  task automatic t_irq;
    xfer(16'h0004);
    irq_event = 8'h02;
    repeat (8) @(negedge clk);
    cmp("masked", 8'h01, {7'h0, irq_n});
    irq_event = 8'h04;
    repeat (8) @(negedge clk);
    cmp("set", 8'h00, {7'h0, irq_n});
    irq_event = 8'h00;
    repeat (8) @(negedge clk);
    cmp("held", 8'h00, {7'h0, irq_n});
    xfer(16'h0104);
    cmp("clr", 8'h01, {7'h0, irq_n});
    $display("t_irq done");
  endtask : t_irq
  task automatic t_reset;
    hw_reset_n = 0;
    repeat (8) @(negedge clk);
    hw_reset_n = 1;
    repeat (4) @(negedge clk);
    cmp("img5", REG_RESET, reg_image[47:40]);
    control_mode_select = 0;
    mon = 1;
    repeat (8) @(negedge clk);
    cmp("mon", 8'h01, {7'h0, receive_monitor_select});
    cmp("oe_hw", 8'h01, {7'h0, serial_data_out_oe_n});
    $display("t_reset done");
  endtask : t_reset
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    hw_reset_n = 1;
    repeat (4) @(negedge clk);
    t_regs();
    t_irq();
    t_reset();
    stop_test();
  end
  initial
  begin
    #50000;
    error_cnt++;
    stop_test();
  end
endmodule : shrp_port_bench

// file: verification/shrp_port_properties.sv
// Checker for the serial host register port
`timescale 1ns/1ps
// ====
// Properties
module shrp_port_properties (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_data_out_oe_n,
  input wire logic control_mode_select,
  input wire logic hw_reset_n,
  input wire logic [7:0] irq_event,
  input wire logic irq_n,
  input wire logic [shrp_pkg::REG_COUNT*8-1:0] reg_image,
  input wire logic receive_monitor_select
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    !irq_n && hw_reset_n && !serial_clk;
  endsequence
  chk_irq_hold: assert property (s_quiet [*8] |=> !irq_n)
    else $error("irq released");
  chk_irq_raise: assert property (hw_reset_n && control_mode_select [*6] ##0 |(irq_event & reg_image[7:0]) |-> ##[1:6] !irq_n)
    else $error("irq missing");
  chk_irq_masked: assert property (reg_image[7:0] == 8'h00 |-> irq_n)
    else $error("irq unmasked");
  chk_hw_reset: assert property (!hw_reset_n [*8] |-> reg_image == '0 && irq_n)
    else $error("reset ignored");
  chk_oe_hwmode: assert property (!control_mode_select [*6] |-> serial_data_out_oe_n)
    else $error("pin driven");
  chk_mon_host: assert property (control_mode_select [*6] |-> !receive_monitor_select)
    else $error("monitor set");
  chk_oe_idle: assert property (chip_select_n [*4] |-> serial_data_out_oe_n)
    else $error("idle drive");
  chk_oe_end: assert property ($rose(chip_select_n) |-> ##[0:4] serial_data_out_oe_n)
    else $error("no release");
endmodule : shrp_port_properties
bind shrp_port shrp_port_properties i_chk (.clk, .rst_n, .serial_clk, .chip_select_n,
  .serial_data_out_oe_n, .control_mode_select, .hw_reset_n, .irq_event, .irq_n,
  .reg_image, .receive_monitor_select);
